// ==== hw/pex_pkg.sv ====
// Purpose: shared constants and helpers for the two-wire port expander
// Assumes: apb slave with 32-bit data, one word per register
// Notes: byte layouts for port and change-flag bytes live here
package pex_pkg;

  // apb register byte offsets
  localparam logic [11:0] PEX_CTRL_OFF = 12'h000;
  localparam logic [11:0] PEX_STATUS_OFF = 12'h004;
  localparam logic [11:0] PEX_PORT_OFF = 12'h008;

  // ctrl, status and port field positions
  localparam int PEX_CTRL_EN_BIT = 0;
  localparam int PEX_ST_ALERT_BIT = 0;
  localparam int PEX_ST_HOLD_BIT = 1;
  localparam int PEX_ST_BUSY_BIT = 2;
  localparam int PEX_PORT_FLAG_LSB = 8;
  localparam int PEX_PORT_MASK_LSB = 12;

  // reset values
  localparam logic PEX_CTRL_EN_RST = 1'b1;
  localparam logic [3:0] PEX_OUT_RST = 4'hf;
  localparam logic [3:0] PEX_MASK_RST = 4'h0;

  // fixed upper slave address bits
  localparam logic [2:0] PEX_ADDR_TOP = 3'h6;

  // bit count of one byte on the wire
  localparam logic [3:0] PEX_BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {
    PEX_IDLE,
    PEX_ADDR,
    PEX_ADDR_ACK,
    PEX_RD_BYTE,
    PEX_RD_ACK,
    PEX_WR_BYTE,
    PEX_WR_ACK,
    PEX_SKIP
  } pex_fsm_e;

  // outs[0..3] sit at byte bits 0,1,6,7; inputs at bits 2..5
  function automatic logic [7:0] pex_port_byte(input logic [3:0] outs, input logic [3:0] ins);
    pex_port_byte = {outs[3], outs[2], ins, outs[1], outs[0]};
  endfunction : pex_port_byte

  function automatic logic [7:0] pex_flag_byte(input logic [3:0] flags);
    pex_flag_byte = {2'h0, flags, 2'h0};
  endfunction : pex_flag_byte

endpackage : pex_pkg

// ==== hw/pex_expander.sv ====
// Purpose: two-wire slave transactions of a 4-out / 4-in port expander
// Assumes: scl, sda and all pins are asynchronous and oversampled by pclk
// Notes: register file over apb gives enable, status and a state view
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pex_expander #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire bus, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address select pins, four levels each
  input wire logic [1:0] addr_select_low,
  input wire logic [1:0] addr_select_high,
  // port pins
  input wire logic [3:0] monitored_inputs,
  output logic drive_bit_zero,
  output logic drive_bit_one,
  output logic drive_bit_six,
  output logic drive_bit_seven,
  output logic alert_n
);
  import pex_pkg::*;

  // offsets are 12-bit constants, so a wider bus would select past their msb
  if (ADDR_W < 4 || ADDR_W > 12)
  begin : g_bad_addr_w
    $error("pex_expander: ADDR_W must be 4..12");
  end

  typedef struct packed {
    logic [2:0] scl_sh;
    logic [2:0] sda_sh;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic scl_f;
    logic sda_f;
    logic [7:0] pin_f;
    logic scl_p;
    logic sda_p;
    pex_fsm_e fsm;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic rw;
    logic flag_phase;
    logic mack;
    logic oe;
    logic hold;
    logic [3:0] snapshot;
    logic [3:0] flags;
    logic [3:0] outs;
    logic [3:0] mask;
    logic alert_n;
    logic en;
    logic [31:0] rdata;
  } pex_state_s;

  pex_state_s q;
  pex_state_s d;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic snap_take;
  logic addr_match;
  logic wr_take;
  logic mapped;
  logic [3:0] ins_f;
  logic [3:0] sel_f;
  logic [31:0] rd_mux;

  assign ins_f = q.pin_f[3:0];
  assign sel_f = q.pin_f[7:4];
  assign scl_rise = q.scl_f & ~q.scl_p;
  assign scl_fall = ~q.scl_f & q.scl_p;
  // data edge with clock high frames a transfer
  assign start_det = q.scl_f & q.scl_p & q.sda_p & ~q.sda_f;
  assign stop_det = q.scl_f & q.scl_p & ~q.sda_p & q.sda_f;
  assign addr_match = (q.sr[7:1] == {PEX_ADDR_TOP, sel_f});
  assign mapped = (paddr[ADDR_W-1:0] == PEX_CTRL_OFF[ADDR_W-1:0])
      || (paddr[ADDR_W-1:0] == PEX_STATUS_OFF[ADDR_W-1:0])
      || (paddr[ADDR_W-1:0] == PEX_PORT_OFF[ADDR_W-1:0]);

  always_comb
  begin
    rd_mux = 32'h0;
    if (paddr[ADDR_W-1:0] == PEX_CTRL_OFF[ADDR_W-1:0])
    begin
      rd_mux[PEX_CTRL_EN_BIT] = q.en;
    end
    else if (paddr[ADDR_W-1:0] == PEX_STATUS_OFF[ADDR_W-1:0])
    begin
      rd_mux[PEX_ST_ALERT_BIT] = ~q.alert_n;
      rd_mux[PEX_ST_HOLD_BIT] = q.hold;
      rd_mux[PEX_ST_BUSY_BIT] = (q.fsm != PEX_IDLE);
    end
    else if (paddr[ADDR_W-1:0] == PEX_PORT_OFF[ADDR_W-1:0])
    begin
      rd_mux[7:0] = pex_port_byte(q.outs, q.snapshot);
      rd_mux[PEX_PORT_FLAG_LSB +: 4] = q.flags;
      rd_mux[PEX_PORT_MASK_LSB +: 4] = q.mask;
    end
  end

  always_comb
  begin
    d = q;
    snap_take = 1'b0;
    wr_take = 1'b0;

    // synchronisers: first stage feeds only the second
    d.scl_sh = {q.scl_sh[1:0], scl_in};
    d.sda_sh = {q.sda_sh[1:0], sda_in};
    d.pin_s1 = {addr_select_high, addr_select_low, monitored_inputs};
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    if (q.scl_sh[1] == q.scl_sh[2])
    begin
      d.scl_f = q.scl_sh[2];
    end
    if (q.sda_sh[1] == q.sda_sh[2])
    begin
      d.sda_f = q.sda_sh[2];
    end
    d.pin_f = (~(q.pin_s2 ^ q.pin_s3) & q.pin_s3) | ((q.pin_s2 ^ q.pin_s3) & q.pin_f);
    d.scl_p = q.scl_f;
    d.sda_p = q.sda_f;

    // apb: zero wait, read data staged in the setup cycle
    if (psel && !penable && !pwrite)
    begin
      d.rdata = rd_mux;
    end
    if (psel && penable && pwrite && (paddr[ADDR_W-1:0] == PEX_CTRL_OFF[ADDR_W-1:0]))
    begin
      d.en = pwdata[PEX_CTRL_EN_BIT];
    end

    case (q.fsm)
      PEX_IDLE:
      begin
        d.oe = 1'b0;
      end
      PEX_ADDR:
      begin
        if (scl_rise)
        begin
          d.sr = {q.sr[6:0], q.sda_f};
          d.cnt = q.cnt + 4'h1;
        end
        else if (scl_fall && q.cnt == PEX_BYTE_BITS)
        begin
          if (addr_match)
          begin
            d.fsm = PEX_ADDR_ACK;
            d.rw = q.sr[0];
            d.oe = 1'b1;
            snap_take = 1'b1;
            d.hold = 1'b1;
          end
          else
          begin
            d.fsm = PEX_SKIP;
          end
        end
      end
      PEX_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          d.cnt = 4'h0;
          if (q.rw)
          begin
            d.fsm = PEX_RD_BYTE;
            d.flag_phase = 1'b0;
            d.sr = pex_port_byte(q.outs, q.snapshot);
            d.oe = ~d.sr[7];
          end
          else
          begin
            d.fsm = PEX_WR_BYTE;
            d.oe = 1'b0;
          end
        end
      end
      PEX_RD_BYTE:
      begin
        if (scl_rise)
        begin
          d.cnt = q.cnt + 4'h1;
        end
        else if (scl_fall)
        begin
          if (q.cnt == PEX_BYTE_BITS)
          begin
            d.fsm = PEX_RD_ACK;
            d.oe = 1'b0;
            // flag byte out: resample and restart detection
            snap_take = q.flag_phase;
          end
          else
          begin
            d.sr = {q.sr[6:0], 1'b0};
            d.oe = ~d.sr[7];
          end
        end
      end
      PEX_RD_ACK:
      begin
        if (scl_rise)
        begin
          d.mack = ~q.sda_f;
        end
        else if (scl_fall)
        begin
          // master nack ends the data phase
          if (!q.mack)
          begin
            d.fsm = PEX_SKIP;
            d.oe = 1'b0;
          end
          else
          begin
            d.fsm = PEX_RD_BYTE;
            d.cnt = 4'h0;
            d.flag_phase = ~q.flag_phase;
            if (q.flag_phase)
            begin
              d.sr = pex_port_byte(q.outs, q.snapshot);
            end
            else
            begin
              d.sr = pex_flag_byte(q.flags);
            end
            d.oe = ~d.sr[7];
          end
        end
      end
      PEX_WR_BYTE:
      begin
        if (scl_rise)
        begin
          d.sr = {q.sr[6:0], q.sda_f};
          d.cnt = q.cnt + 4'h1;
        end
        else if (scl_fall && q.cnt == PEX_BYTE_BITS)
        begin
          d.fsm = PEX_WR_ACK;
          d.oe = 1'b1;
          wr_take = 1'b1;
        end
      end
      PEX_WR_ACK:
      begin
        if (scl_fall)
        begin
          d.fsm = PEX_WR_BYTE;
          d.cnt = 4'h0;
          d.oe = 1'b0;
        end
      end
      PEX_SKIP:
      begin
        d.oe = 1'b0;
      end
      default:
      begin
        d.fsm = PEX_IDLE;
        d.oe = 1'b0;
      end
    endcase

    // outputs and mask update in one cycle from the same byte
    if (wr_take)
    begin
      d.outs = {q.sr[7], q.sr[6], q.sr[1], q.sr[0]};
      d.mask = q.sr[5:2];
    end

    // snapshot equals the live value, so a change this cycle is not lost
    if (snap_take)
    begin
      d.snapshot = ins_f;
      d.flags = 4'h0;
    end
    else
    begin
      d.flags = q.flags | (ins_f ^ q.snapshot);
    end

    // frame conditions override the byte machine
    if (start_det)
    begin
      d.fsm = PEX_ADDR;
      d.cnt = 4'h0;
      d.oe = 1'b0;
    end
    else if (stop_det)
    begin
      d.fsm = PEX_IDLE;
      d.oe = 1'b0;
      d.hold = 1'b0;
    end
    if (!q.en)
    begin
      d.fsm = PEX_IDLE;
      d.oe = 1'b0;
      d.hold = 1'b0;
    end

    d.alert_n = ~((|(d.flags & d.mask)) & ~d.hold);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.scl_sh <= 3'h7;
      q.sda_sh <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.fsm <= PEX_IDLE;
      q.outs <= PEX_OUT_RST;
      q.mask <= PEX_MASK_RST;
      q.alert_n <= 1'b1;
      q.en <= PEX_CTRL_EN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign sda_out = 1'b0;
  assign sda_oe = q.oe;
  assign drive_bit_zero = q.outs[0];
  assign drive_bit_one = q.outs[1];
  assign drive_bit_six = q.outs[2];
  assign drive_bit_seven = q.outs[3];
  assign alert_n = q.alert_n;

  // checks
  a_addr_ack_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == PEX_ADDR) && (d.fsm == PEX_ADDR_ACK) |=> q.oe && q.hold)
    else $error("address ack not driven");

  a_snap_at_ack: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == PEX_ADDR) && (d.fsm == PEX_ADDR_ACK) |=>
      (q.snapshot == $past(ins_f)) && (q.flags == 4'h0))
    else $error("snapshot not taken at address ack");

  a_alert_released: assert property (@(posedge pclk) disable iff (!presetn)
    q.hold |-> q.alert_n)
    else $error("alert asserted during open transfer");

  a_alert_level: assert property (@(posedge pclk) disable iff (!presetn)
    !q.hold && (|(q.flags & q.mask)) |-> !q.alert_n)
    else $error("alert missing for enabled flag");

  a_flags_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !snap_take |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
    else $error("change flag dropped without clear");

  a_change_latch: assert property (@(posedge pclk) disable iff (!presetn)
    !snap_take && (ins_f != q.snapshot) ##1 !snap_take |=>
      (q.flags & $past(ins_f ^ q.snapshot, 2)) == $past(ins_f ^ q.snapshot, 2))
    else $error("input change not latched");

  a_write_apply: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take |=> (q.outs == {$past(q.sr[7]), $past(q.sr[6]), $past(q.sr[1]), $past(q.sr[0])})
      && (q.mask == $past(q.sr[5:2])))
    else $error("write byte not applied");

  a_port_first: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == PEX_ADDR_ACK) && scl_fall && q.rw && !start_det && !stop_det && q.en |=>
      q.sr == pex_port_byte(q.outs, q.snapshot))
    else $error("first read byte is not the port byte");

  a_flag_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == PEX_RD_BYTE) && (d.fsm == PEX_RD_ACK) && q.flag_phase |=>
      (q.flags == 4'h0) && (q.snapshot == $past(ins_f)))
    else $error("flags not restarted after flag byte");

  a_master_turn: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == PEX_RD_ACK) |-> !q.oe)
    else $error("sda driven during master ack");

  c_read_two: cover property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == PEX_RD_ACK) && q.flag_phase && scl_fall);
  c_write_byte: cover property (@(posedge pclk) disable iff (!presetn) wr_take);
  c_alert_after_stop: cover property (@(posedge pclk) disable iff (!presetn)
    q.hold && stop_det ##[1:4] !q.alert_n);

endmodule : pex_expander

`default_nettype wire

// ==== tb/pex_tb_master.sv ====
// Purpose: behavioural two-wire bus master for the port expander bench
// Assumes: sda has a pull-up; pclk paces every edge of scl and sda
// Notes: scl stands high between frames; phases are 6 pclk each, 48 ns period
`timescale 1ns/1ps
`default_nettype none

module pex_tb_master (
  // pacing clock
  input wire logic pclk,
  // two-wire bus
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // data set mid-low, sampled mid-high, so it never moves while scl is high
  // slave turns sda round about 5 pclk after the pin falls, before the next rise
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= !b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda;
    tick(3);
    scl <= 1'b0;
    tick(3);
  endtask : bit_io

  task automatic start();
    sda_oe <= 1'b1;
    tick(6);
    scl <= 1'b0;
    tick(3);
  endtask : start

  task automatic stop();
    sda_oe <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(6);
    sda_oe <= 1'b0;
    tick(6);
  endtask : stop

  // msb first; b9 is what the master puts on the ninth bit
  task automatic byte_io(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
                         output logic nine);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(b9, nine);
  endtask : byte_io

endmodule : pex_tb_master
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench of the port expander transactions
// Assumes: master model paces scl from pclk; sda wire is a wired-and
// Notes: expected bytes worked out by hand from the byte layouts
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pex_pkg::*;
  localparam logic [6:0] MY = 7'h69;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic scl, m_oe, sda_oe, sda_out, alert_n, nine;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] asel_lo, asel_hi;
  logic [3:0] ins;
  wire logic [3:0] outs;
  logic [7:0] rx;
  logic [6:0] bad [3] = '{7'h68, 7'h79, 7'h65};
  wire logic sda;
  int num_errors = 0;
  int checks_done = 0;

  assign sda = !m_oe && !(sda_oe && !sda_out);
  always #2 pclk = !pclk;

  pex_expander i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_low(asel_lo), .addr_select_high(asel_hi), .monitored_inputs(ins),
    .drive_bit_zero(outs[0]), .drive_bit_one(outs[1]), .drive_bit_six(outs[2]),
    .drive_bit_seven(outs[3]), .alert_n(alert_n));

  pex_tb_master i_mst (.pclk(pclk), .sda(sda), .scl(scl), .sda_oe(m_oe));

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never re-drives psel in this time step
    @(posedge pclk);
  endtask : apb

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // bounded run: whole sequence is under two thousand cycles
  initial
  begin
    wt(20000);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    asel_lo = 2'h1;
    asel_hi = 2'h2;
    ins = 4'h0;
    wt(12);
    presetn <= 1'b1;
    wt(10);
    chk("outs reset", outs, PEX_OUT_RST);
    chk("alert reset", alert_n, 1'b1);
    apb(1'b0, PEX_CTRL_OFF, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", perr, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    i_mst.start();
    i_mst.byte_io({MY, 1'b0}, 1'b1, rx, nine);
    chk("wr addr ack", nine, 1'b0);
    i_mst.byte_io(8'hc2, 1'b1, rx, nine);
    chk("wr ack 1", nine, 1'b0);
    chk("outs 1", outs, 4'he);
    i_mst.byte_io(8'h3d, 1'b1, rx, nine);
    chk("wr ack 2", nine, 1'b0);
    chk("outs 2", outs, 4'h1);
    i_mst.stop();
    apb(1'b0, PEX_PORT_OFF, 32'h0);
    chk("mask", rd[15:12], 4'hf);
    $display("test write done");
    foreach (bad[i])
    begin
      i_mst.start();
      i_mst.byte_io({bad[i], 1'b0}, 1'b1, rx, nine);
      chk("foreign addr", nine, 1'b1);
      i_mst.stop();
    end
    apb(1'b1, PEX_CTRL_OFF, 32'h0);
    i_mst.start();
    i_mst.byte_io({MY, 1'b0}, 1'b1, rx, nine);
    chk("disabled ack", nine, 1'b1);
    i_mst.stop();
    apb(1'b1, PEX_CTRL_OFF, 32'h1);
    apb(1'b0, PEX_CTRL_OFF, 32'h0);
    chk("ctrl enable", rd, 32'h1);
    $display("test address done");
    ins <= 4'h5;
    wt(12);
    chk("alert on change", alert_n, 1'b0);
    apb(1'b0, PEX_STATUS_OFF, 32'h0);
    chk("status alert", rd, 32'h1);
    ins <= 4'h0;
    wt(12);
    apb(1'b0, PEX_PORT_OFF, 32'h0);
    chk("flags sticky", rd[11:8], 4'h5);
    i_mst.start();
    i_mst.byte_io({MY, 1'b0}, 1'b1, rx, nine);
    chk("alert wr release", alert_n, 1'b1);
    i_mst.byte_io(8'h3d, 1'b1, rx, nine);
    i_mst.stop();
    wt(12);
    chk("alert cleared", alert_n, 1'b1);
    $display("test alert done");
    ins <= 4'h3;
    wt(12);
    chk("alert before rd", alert_n, 1'b0);
    i_mst.start();
    i_mst.byte_io({MY, 1'b1}, 1'b1, rx, nine);
    chk("rd addr ack", nine, 1'b0);
    chk("alert rd release", alert_n, 1'b1);
    fork
      i_mst.byte_io(8'hff, 1'b0, rx, nine);
      begin
        wt(60);
        ins <= 4'hb;
      end
    join
    chk("port byte", rx, 8'h0d);
    chk("alert held", alert_n, 1'b1);
    i_mst.byte_io(8'hff, 1'b0, rx, nine);
    chk("flag byte", rx, 8'h20);
    i_mst.byte_io(8'hff, 1'b1, rx, nine);
    chk("port byte again", rx, 8'h2d);
    i_mst.stop();
    wt(12);
    chk("alert after read", alert_n, 1'b1);
    $display("test long read done");
    i_mst.start();
    i_mst.byte_io({MY, 1'b1}, 1'b1, rx, nine);
    fork
      i_mst.byte_io(8'hff, 1'b1, rx, nine);
      begin
        wt(60);
        ins <= 4'h0;
      end
    join
    chk("one byte read", rx, 8'h2d);
    chk("alert held 2", alert_n, 1'b1);
    i_mst.stop();
    wt(12);
    chk("alert after stop", alert_n, 1'b0);
    apb(1'b0, PEX_PORT_OFF, 32'h0);
    chk("flags in read", rd[11:8], 4'hb);
    $display("test short read done");
    report_and_stop();
  end

endmodule : tb
`default_nettype wire
